/* File: fsw_pkg.sv */
// Constants shared by the fail-safe watchdog and power control block.
// Assumes a 10 MHz system clock and a word-addressed register port.
package fsw_pkg;
  localparam int CLK_MHZ = 10;
  localparam int T_STAB_US = 1000;
  localparam int STAB_CYC = T_STAB_US * CLK_MHZ;
  localparam int WDT_RST_CYC = 24;
  // Register offsets.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RELOAD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;
  // Control register fields, all write-one actions except the slow-down level.
  localparam int CTRL_IDLE = 0;
  localparam int CTRL_PDOWN = 1;
  localparam int CTRL_SLOW = 2;
  localparam int CTRL_REFRESH = 3;
  localparam int CTRL_START = 4;
  // Reload register fields.
  localparam int RELOAD_PRE16 = 7;
  // Status register fields.
  localparam int ST_CAUSE = 0;
  localparam int ST_RUN = 1;
  localparam int ST_IDLE = 2;
  localparam int ST_PDOWN = 3;
  localparam int ST_OSCFAIL = 4;
  localparam int ST_SLOW = 5;
  // Divider figures.
  localparam logic [2:0] BASE_DIV_LAST = 3'h5;
  localparam logic [3:0] PRE16_LAST = 4'hf;
  localparam logic [4:0] SLOW_LAST = 5'h1f;
  localparam logic [14:0] WDT_MAX = 15'h7fff;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  typedef enum logic [2:0] {
    FSW_POR = 3'b000,
    FSW_STAB = 3'b001,
    FSW_RUN = 3'b010,
    FSW_PDOWN = 3'b011,
    FSW_WAKE = 3'b100,
    FSW_WSTAB = 3'b101
  } fsw_state_t;
endpackage : fsw_pkg

/* File: fsw_top.sv */
// Fail-safe watchdog, oscillator supervisor and power-saving mode control.
// Assumes oscillator and wake pins arrive asynchronously and are sampled here;
// the main oscillator input must toggle slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
module fsw_top #(
  parameter int STAB_CYCLES = fsw_pkg::STAB_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port.
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Pins.
  input wire logic ext_rst_n_i,
  input wire logic main_osc_i,
  input wire logic rc_osc_i,
  input wire logic wake_pin_a_i,
  input wire logic wake_pin_b_i,
  // Events from the rest of the core.
  input wire logic irq_pending_i,
  // Clocking and reset control, and the wake interrupt.
  output logic sys_rst_o,
  output logic clk_sel_rc_o,
  output logic main_osc_run_o,
  output logic rc_osc_run_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic pd_wake_irq_o
);
  import fsw_pkg::*;

  fsw_state_t state;
  fsw_state_t next_state;
  logic [1:0] ext_rst_sync;
  logic [1:0] main_sync;
  logic [1:0] rc_sync;
  logic [1:0] wake_a_sync;
  logic [1:0] wake_b_sync;
  logic main_prev;
  logic rc_prev;
  logic main_seen;
  logic osc_fail;
  logic osc_good;
  logic [13:0] stab_cnt;
  logic stab_done;
  logic hw_reset;
  logic ext_reset;
  logic [4:0] slow_cnt;
  logic slow_en;
  logic slow_tick;
  logic idle;
  logic [7:0] reload_value;
  logic [14:0] wdt_cnt;
  logic wdt_run;
  logic refresh_armed;
  logic [2:0] base_cnt;
  logic half_cnt;
  logic [3:0] pre16_cnt;
  logic wdt_tick;
  logic wdt_ovf;
  logic [4:0] wdt_rst_cnt;
  logic cause_flag;
  logic wr_ctrl;
  logic do_start;
  logic do_refresh;
  logic bus_wr;
  logic pd_req;
  logic idle_req;
  logic rc_rise;
  logic main_rise;
  logic wdt_fire;

  // Wake pins reset high, their idle level, so leaving reset cannot look like a wake.
  // Pin inputs pass two flip-flops before any use.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_rst_sync <= 2'h3;
      main_sync <= 2'h0;
      rc_sync <= 2'h0;
      wake_a_sync <= 2'h3;
      wake_b_sync <= 2'h3;
    end else begin
      ext_rst_sync <= {ext_rst_sync[0], ext_rst_n_i};
      main_sync <= {main_sync[0], main_osc_i};
      rc_sync <= {rc_sync[0], rc_osc_i};
      wake_a_sync <= {wake_a_sync[0], wake_pin_a_i};
      wake_b_sync <= {wake_b_sync[0], wake_pin_b_i};
    end
  end

  assign ext_reset = ~ext_rst_sync[1];
  assign hw_reset = srst_i | ext_reset;

  // Edges are taken from the second synchroniser stage only, so a metastable first
  // stage never reaches the compare.
  assign rc_rise = rc_sync[1] & ~rc_prev;
  assign main_rise = main_sync[1] & ~main_prev;

  // Frequency compare: each rising RC edge must see a main oscillator edge since the last one.
  // A single missing edge counts as a failure, which keeps the decision fast at power-on.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      main_prev <= 1'b0;
      rc_prev <= 1'b0;
      main_seen <= 1'b0;
      osc_fail <= 1'b1;
      osc_good <= 1'b0;
    end else begin
      main_prev <= main_sync[1];
      rc_prev <= rc_sync[1];
      if (state == FSW_PDOWN) begin
        main_seen <= 1'b0;
        osc_good <= 1'b0;
      end else if (rc_rise) begin
        main_seen <= 1'b0;
        osc_fail <= ~main_seen;
        osc_good <= main_seen;
      end else if (main_rise) begin
        main_seen <= 1'b1;
      end
    end
  end

  // Supervisor sequence.
  assign stab_done = (stab_cnt == 14'(STAB_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      FSW_POR: begin
        if (osc_good && !osc_fail) next_state = FSW_STAB;
      end
      FSW_STAB: begin
        if (osc_fail) next_state = FSW_POR;
        else if (stab_done) next_state = FSW_RUN;
      end
      FSW_RUN: begin
        if (osc_fail) next_state = FSW_POR;
        else if (pd_req) next_state = FSW_PDOWN;
      end
      FSW_PDOWN: begin
        if (!wake_a_sync[1] || !wake_b_sync[1]) next_state = FSW_WAKE;
      end
      // Wake-up never asserts the core reset; a slow oscillator only delays the interrupt.
      FSW_WAKE: begin
        if (osc_good && !osc_fail) next_state = FSW_WSTAB;
      end
      FSW_WSTAB: begin
        if (osc_fail) next_state = FSW_WAKE;
        else if (stab_done) next_state = FSW_RUN;
      end
      default: next_state = FSW_POR;
    endcase
  end

  // A hardware reset, or an oscillator failure in FSW_STAB or FSW_RUN, returns the supervisor to power-on; the watchdog pulse does not.
  always_ff @(posedge clk_i) begin
    if (hw_reset) begin
      state <= FSW_POR;
    end else begin
      state <= next_state;
    end
  end

  // The count restarts on every state change, so each wait is a full period.
  always_ff @(posedge clk_i) begin
    if (hw_reset || state != next_state) begin
      stab_cnt <= 14'h0000;
    end else if (state == FSW_STAB || state == FSW_WSTAB) begin
      stab_cnt <= stab_cnt + 14'h0001;
    end
  end

  // Register port decode. Writes are dropped while the core is held in reset, so a
  // stray write during the watchdog reset pulse cannot enter power-down.
  assign bus_wr = wr_i && !sys_rst_o;
  assign wr_ctrl = bus_wr && (addr_i == ADDR_CTRL);
  assign pd_req = wr_ctrl && wdata_i[CTRL_PDOWN];
  assign idle_req = wr_ctrl && wdata_i[CTRL_IDLE];
  // The refresh pair must be the next two writes to control, with no other write between.
  assign do_start = wr_ctrl && wdata_i[CTRL_START] && !wdt_run;
  assign do_refresh = wr_ctrl && wdata_i[CTRL_START] && wdt_run && refresh_armed;

  // Any bus write, whatever its address, ends the arming, so the pair must be back to back.
  always_ff @(posedge clk_i) begin
    if (hw_reset || sys_rst_o) begin
      refresh_armed <= 1'b0;
    end else if (wr_i) begin
      refresh_armed <= wr_ctrl && wdata_i[CTRL_REFRESH] && !wdata_i[CTRL_START];
    end
  end

  always_ff @(posedge clk_i) begin
    if (hw_reset || sys_rst_o) begin
      slow_en <= 1'b0;
      reload_value <= RELOAD_RST;
    end else begin
      if (wr_ctrl) begin
        slow_en <= wdata_i[CTRL_SLOW];
      end
      if (bus_wr && addr_i == ADDR_RELOAD) begin
        reload_value <= wdata_i;
      end
    end
  end

  // Slow-down divider: one enable pulse every 32 cycles, shared by core and peripherals.
  assign slow_tick = slow_en ? (slow_cnt == SLOW_LAST) : 1'b1;

  // Holding the divider clear with the mode off puts the first slow pulse a full 32 cycles on.
  always_ff @(posedge clk_i) begin
    if (hw_reset || !slow_en) begin
      slow_cnt <= 5'h00;
    end else begin
      slow_cnt <= slow_cnt + 5'h01;
    end
  end

  // Idle: a software level cleared by an enabled interrupt or a reset.
  always_ff @(posedge clk_i) begin
    if (hw_reset || sys_rst_o) begin
      idle <= 1'b0;
    end else if (irq_pending_i) begin
      idle <= 1'b0;
    end else if (idle_req && state == FSW_RUN) begin
      idle <= 1'b1;
    end
  end

  // Watchdog prescaler: divide by 6, then by 2, then optionally by 16.
  // Advances only on peripheral clock enables outside idle, so slow-down stretches it and
  // idle or power-down freezes it.
  assign wdt_tick = periph_clk_en_o && !idle && (base_cnt == BASE_DIV_LAST) && half_cnt
    && (!reload_value[RELOAD_PRE16] || pre16_cnt == PRE16_LAST);

  always_ff @(posedge clk_i) begin
    if (hw_reset || sys_rst_o || !wdt_run) begin
      base_cnt <= 3'h0;
      half_cnt <= 1'b0;
      pre16_cnt <= 4'h0;
    end else if (periph_clk_en_o && !idle) begin
      if (base_cnt == BASE_DIV_LAST) begin
        base_cnt <= 3'h0;
        half_cnt <= ~half_cnt;
        if (half_cnt) pre16_cnt <= pre16_cnt + 4'h1;
      end else begin
        base_cnt <= base_cnt + 3'h1;
      end
    end
  end

  assign wdt_ovf = wdt_tick && (wdt_cnt == WDT_MAX);
  assign wdt_fire = wdt_ovf && wdt_run;

  // A new reload count takes effect only at the next start or refresh; the divide-by-16 bit applies at once.
  always_ff @(posedge clk_i) begin
    if (hw_reset || sys_rst_o) begin
      wdt_run <= 1'b0;
      wdt_cnt <= 15'h0000;
    end else begin
      if (do_start) begin
        wdt_run <= 1'b1;
      end
      if (do_start || do_refresh) begin
        wdt_cnt <= {reload_value[6:0], 8'h00};
      end else if (wdt_run && wdt_tick) begin
        wdt_cnt <= wdt_cnt + 15'h0001;
      end
    end
  end

  // Watchdog reset pulse and its cause; the overflow wins over a hardware reset for the cause, srst_i wins for the pulse.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wdt_rst_cnt <= 5'h00;
    end else if (wdt_fire) begin
      wdt_rst_cnt <= 5'(WDT_RST_CYC);
    end else if (wdt_rst_cnt != 5'h00) begin
      wdt_rst_cnt <= wdt_rst_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wdt_fire) begin
      cause_flag <= 1'b1;
    end else if (hw_reset) begin
      cause_flag <= 1'b0;
    end
  end

  // Registered outputs. Oscillator enables follow the next state, so they drop on the
  // very edge at which power-down begins.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_rst_o <= 1'b1;
      clk_sel_rc_o <= 1'b1;
      main_osc_run_o <= 1'b1;
      rc_osc_run_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      pd_wake_irq_o <= 1'b0;
    end else begin
      sys_rst_o <= ext_reset || next_state == FSW_POR || next_state == FSW_STAB
        || wdt_fire || wdt_rst_cnt > 5'h01;
      clk_sel_rc_o <= osc_fail;
      main_osc_run_o <= next_state != FSW_PDOWN;
      rc_osc_run_o <= next_state != FSW_PDOWN;
      // The idle write gates the processor at once, on the same edge at which the idle level is set.
      cpu_clk_en_o <= next_state == FSW_RUN && !idle && !idle_req
        && slow_tick;
      periph_clk_en_o <= next_state == FSW_RUN && slow_tick;
      pd_wake_irq_o <= state == FSW_WSTAB && next_state == FSW_RUN;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        // Bits sit at their field positions, so control reads follow the write layout.
        ADDR_CTRL: begin
          rdata_o <= 16'h0000;
          rdata_o[CTRL_IDLE] <= idle;
          rdata_o[CTRL_SLOW] <= slow_en;
          rdata_o[CTRL_REFRESH] <= refresh_armed;
          rdata_o[CTRL_START] <= wdt_run;
        end
        ADDR_RELOAD: rdata_o <= {8'h00, reload_value};
        ADDR_STATUS: begin
          rdata_o <= 16'h0000;
          rdata_o[ST_CAUSE] <= cause_flag;
          rdata_o[ST_RUN] <= wdt_run;
          rdata_o[ST_IDLE] <= idle;
          rdata_o[ST_PDOWN] <= state == FSW_PDOWN;
          rdata_o[ST_OSCFAIL] <= osc_fail;
          rdata_o[ST_SLOW] <= slow_en;
        end
        ADDR_COUNT: rdata_o <= {1'b0, wdt_cnt};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule : fsw_top
`default_nettype wire

/* File: fsw_top_properties.sv */
// Port-level checker for the fail-safe watchdog and power control block.
// Assumes it is bound to fsw_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fsw_checker (
  // Clock, reset and pins.
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ext_rst_n_i,
  // Observed outputs.
  input wire logic sys_rst_o,
  input wire logic clk_sel_rc_o,
  input wire logic main_osc_run_o,
  input wire logic rc_osc_run_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic pd_wake_irq_o
);
  // Set from power-down until the wake interrupt or a reset: a slow oscillator during
  // wake-up only delays the interrupt and is not a failure in operation.
  logic in_wake;
  always_ff @(posedge clk_i) begin
    if (srst_i || sys_rst_o || pd_wake_irq_o) begin
      in_wake <= 1'b0;
    end else if (!main_osc_run_o) begin
      in_wake <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  chk_por_on_rc: assert property ($fell(srst_i) |-> sys_rst_o && clk_sel_rc_o)
    else $error("core left reset or off rc clock at power-on");
  chk_osc_pair: assert property (main_osc_run_o == rc_osc_run_o)
    else $error("oscillators not stopped and started together");
  chk_pd_no_clk: assert property (!main_osc_run_o |=> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clock enables active with oscillators stopped");
  chk_wake_pulse: assert property (pd_wake_irq_o |-> !sys_rst_o ##1 !pd_wake_irq_o)
    else $error("wake interrupt not a single pulse outside reset");
  chk_wdt_rst_len: assert property ($rose(sys_rst_o) && !clk_sel_rc_o |=> sys_rst_o [*8])
    else $error("watchdog reset too short");
  chk_idle_periph: assert property (cpu_clk_en_o |-> periph_clk_en_o)
    else $error("processor clocked without peripherals");
  chk_fail_rc_rst: assert property ($rose(clk_sel_rc_o) && $past(main_osc_run_o, 2) && !in_wake
    |-> sys_rst_o)
    else $error("switched to rc clock without holding reset");
  chk_ext_rst: assert property ($fell(ext_rst_n_i) |-> ##[1:4] sys_rst_o)
    else $error("external reset not passed to core");
  cov_wake: cover property (pd_wake_irq_o);
  cov_wdt_rst: cover property ($rose(sys_rst_o) && !clk_sel_rc_o);
  cov_idle: cover property (periph_clk_en_o && !cpu_clk_en_o);
endmodule : fsw_checker
bind fsw_top fsw_checker fsw_checker_i (.clk_i(clk_i), .srst_i(srst_i),
  .ext_rst_n_i(ext_rst_n_i), .sys_rst_o(sys_rst_o), .clk_sel_rc_o(clk_sel_rc_o),
  .main_osc_run_o(main_osc_run_o), .rc_osc_run_o(rc_osc_run_o),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .pd_wake_irq_o(pd_wake_irq_o));
`default_nettype wire

/* File: fsw_top_test.sv */
// Self-checking bench for the fail-safe watchdog and power control block.
// Assumes fsw_pkg and fsw_top are compiled first; both oscillators are modelled here.
`timescale 1ns/1ps
`default_nettype none
module fsw_top_test;
  import fsw_pkg::*;
  localparam int STAB = 20;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_rst_n_i = 1'b1;
  logic main_osc_i = 1'b0;
  logic rc_osc_i = 1'b0;
  logic wake_pin_a_i = 1'b1;
  logic wake_pin_b_i = 1'b1;
  logic irq_pending_i = 1'b0;
  logic main_ok = 1'b1;
  logic [7:0] cyc = 8'h00;
  logic [15:0] rdata_o, v, w;
  logic sys_rst_o, clk_sel_rc_o, main_osc_run_o, rc_osc_run_o;
  logic cpu_clk_en_o, periph_clk_en_o, pd_wake_irq_o;
  int bad_count = 0;
  int n_checks = 0;
  int nc, np, n;
  always #50 clk_i = ~clk_i;
  // Main toggles at a quarter of the clock and RC at a sixteenth, so main counts as good.
  always @(posedge clk_i) begin
    cyc <= cyc + 8'h01;
    if (main_ok && main_osc_run_o) begin
      main_osc_i <= cyc[1];
    end
    if (rc_osc_run_o) begin
      rc_osc_i <= cyc[3];
    end
  end
  fsw_top #(.STAB_CYCLES(STAB)) fsw_top_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_rst_n_i(ext_rst_n_i),
    .main_osc_i(main_osc_i), .rc_osc_i(rc_osc_i), .wake_pin_a_i(wake_pin_a_i),
    .wake_pin_b_i(wake_pin_b_i), .irq_pending_i(irq_pending_i), .sys_rst_o(sys_rst_o),
    .clk_sel_rc_o(clk_sel_rc_o), .main_osc_run_o(main_osc_run_o), .rc_osc_run_o(rc_osc_run_o),
    .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .pd_wake_irq_o(pd_wake_irq_o));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Sel 0 watches the core reset, sel 1 the wake interrupt; sampled on falling edges.
  task automatic await_lvl(input bit sel, input logic val, input int lim, output int k);
    k = 0;
    while (((sel ? pd_wake_irq_o : sys_rst_o) !== val) && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim) begin
      bad_count++;
      $display("timeout waiting on output %0d", sel);
      summarize();
    end
  endtask : await_lvl
  task automatic count_en(input int cycles);
    nc = 0;
    np = 0;
    repeat (2) @(posedge clk_i);
    repeat (cycles) begin
      @(negedge clk_i);
      nc += int'(cpu_clk_en_o === 1'b1);
      np += int'(periph_clk_en_o === 1'b1);
    end
  endtask : count_en
  task automatic irq_pulse();
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
  endtask : irq_pulse
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    await_lvl(0, 1'b0, 2000, n);
    check("rc_sel", {15'h0, clk_sel_rc_o}, 16'h0);
    rd(4'h2, v);
    check("unmapped", v, 16'h0);
    $display("test power_on done");
    wr(ADDR_RELOAD, 8'h7e);
    wr(ADDR_CTRL, 8'h10);
    rd(ADDR_COUNT, v);
    check("count_start", v >> 8, 16'h007e);
    rd(ADDR_STATUS, v);
    check("running", v & 16'h0002, 16'h0002);
    repeat (100) @(posedge clk_i);
    wr(ADDR_RELOAD, 8'h55);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h10);
    rd(ADDR_COUNT, v);
    check("refresh", v >> 8, 16'h0055);
    check("low_clear", {15'h0, v[7:0] > 8'h01}, 16'h0);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_RELOAD, 8'h33);
    wr(ADDR_CTRL, 8'h10);
    rd(ADDR_COUNT, v);
    check("broken_pair", v >> 8, 16'h0055);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_RELOAD, {i[0], 7'h55});
      rd(ADDR_COUNT, v);
      repeat (i ? 382 : 118) @(posedge clk_i);
      rd(ADDR_COUNT, w);
      check("rate", w - v, i ? 16'd2 : 16'd10);
    end
    $display("test watchdog done");
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_COUNT, v);
    count_en(40);
    rd(ADDR_COUNT, w);
    check("idle_cpu", 16'(nc), 16'd0);
    check("idle_periph", 16'(np), 16'd40);
    check("idle_hold", w, v);
    irq_pulse();
    count_en(8);
    check("idle_exit", 16'(nc), 16'd8);
    wr(ADDR_CTRL, 8'h04);
    count_en(64);
    check("slow", 16'({nc[7:0], np[7:0]}), 16'h0202);
    wr(ADDR_CTRL, 8'h05);
    count_en(64);
    check("slow_idle", 16'({nc[7:0], np[7:0]}), 16'h0002);
    irq_pulse();
    wr(ADDR_CTRL, 8'h00);
    $display("test modes done");
    wr(ADDR_RELOAD, 8'h7f);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h10);
    await_lvl(0, 1'b1, 4000, n);
    await_lvl(0, 1'b0, 100, n);
    check("wdt_len", 16'(n), 16'(WDT_RST_CYC));
    rd(ADDR_STATUS, v);
    check("cause_wdt", v & 16'h0003, 16'h0001);
    @(posedge clk_i);
    ext_rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_rst_n_i <= 1'b1;
    await_lvl(0, 1'b0, 2000, n);
    rd(ADDR_STATUS, v);
    check("cause_ext", v & 16'h0001, 16'h0000);
    $display("test overflow done");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, 8'h02);
      repeat (3) @(negedge clk_i);
      check("osc_stop", {14'h0, main_osc_run_o, rc_osc_run_o}, 16'h0);
      @(posedge clk_i);
      wake_pin_a_i <= (i != 0);
      wake_pin_b_i <= (i == 0);
      repeat (4) @(posedge clk_i);
      wake_pin_a_i <= 1'b1;
      wake_pin_b_i <= 1'b1;
      await_lvl(1, 1'b1, 2000, n);
      check("wake_rst", {15'h0, sys_rst_o}, 16'h0);
      check("osc_run", {14'h0, main_osc_run_o, rc_osc_run_o}, 16'h3);
    end
    $display("test power_down done");
    @(posedge clk_i);
    main_ok <= 1'b0;
    await_lvl(0, 1'b1, 200, n);
    check("fail_rc", {15'h0, clk_sel_rc_o}, 16'h1);
    @(posedge clk_i);
    main_ok <= 1'b1;
    await_lvl(0, 1'b0, 2000, n);
    check("stab", {15'h0, n >= STAB}, 16'h1);
    check("main_sel", {15'h0, clk_sel_rc_o}, 16'h0);
    $display("test osc_fail done");
    summarize();
  end
endmodule : fsw_top_test
`default_nettype wire
